// *** hdl/reset_brownout_pkg.sv ***
package reset_brownout_pkg;
   localparam logic [11:0] ADDR_BROWNOUT_CONTROL_STATUS = 12'h000;
   localparam logic [11:0] ADDR_RESET_STATUS = 12'h004;
   localparam int SOFT_ENABLE_BIT = 7;
   localparam int FAST_START_BIT = 6;
   localparam int READY_BIT = 0;
   localparam logic SOFT_ENABLE_RESET = 1'b1;
   localparam logic FAST_START_RESET = 1'b0;
   localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
   localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
   localparam logic [1:0] MODE_SOFTWARE = 2'h1;
   localparam logic [1:0] MODE_ALWAYS_OFF = 2'h0;
   localparam int CLK_HZ = 100_000_000;
   localparam int POWERUP_DELAY_MS = 64;
   localparam int POWERUP_DELAY_CYCLES = CLK_HZ / 1000 * POWERUP_DELAY_MS;
   localparam int BROWNOUT_FILTER_NS = 1000;
   localparam int BROWNOUT_FILTER_CYCLES = (BROWNOUT_FILTER_NS + 9) / 10;

   typedef struct packed {
      logic [1:0] brownout_mode_select;
      logic brownout_level_select;
      logic powerup_delay_enable_n;
      logic low_power_undervolt_enable;
   } fuse_s;

   typedef struct packed {
      logic power_on_hold;
      logic below_threshold;
      logic monitor_ready;
      logic low_power_undervolt_detect;
   } monitor_s;

   typedef struct packed {
      logic external_reset_pin;
      logic watchdog_reset;
      logic reset_instruction;
      logic stack_overflow;
      logic stack_underflow;
      logic programming_exit;
   } source_s;

   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_DELAY = 3'b010,
      ST_RUN = 3'b100
   } seq_e;
endpackage : reset_brownout_pkg

// *** hdl/reset_brownout_sequencer.sv ***
`timescale 1ns/100ps
// Functional notes
// - Core reset asserted while any reset source requests it.
// - Core held in reset while power-on monitor reports low supply.
// - Power-up delay timer gives 64 ms after power-on or brown-out.
// - Core reset stays asserted while the delay timer runs.
// - Delay timer enabled when active-low enable fuse is clear.
// - Delay timer starts only once power-on and brown-out released.
// - Two-bit field selects always on, off in sleep, software, off.
// - One level-select fuse bit passes straight to the supply monitor.
// - Comparator brown-out only when low supply outlasts the filter time.
// - Modes 11 and 10 wait for ready and supply above threshold.
// - Mode 11 keeps monitor on in sleep; wake not delayed.
// - Mode 10 turns monitor off in sleep; wake waits for ready.
// - Mode 01 soft enable switches monitor; start-up never waits.
// - Software mode protection acts once ready; sleep changes nothing.
// - Forced-on cases add no extra start-up delay beyond ready.
// - Ready flag bit 0 reads 1 while brown-out circuit is active.
// - Soft enable bit 7 resets to 1 on power/brown-out only.
// - Modes 10 and 01: fast-start bit forces the bandgap on.
// - Modes 11 and 00: fast-start bit stored but has no effect.
// - Low-power detector request ORed into the brown-out request.
// - Execution starts after delay timer done and pin released.
module reset_brownout_sequencer #(
   parameter int POWERUP_CYCLES = reset_brownout_pkg::POWERUP_DELAY_CYCLES,
   parameter int FILTER_CYCLES = reset_brownout_pkg::BROWNOUT_FILTER_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire reset_brownout_pkg::fuse_s fuse,
   input wire reset_brownout_pkg::monitor_s monitor,
   input wire reset_brownout_pkg::source_s source,
   input wire logic sleep_mode,
   input wire reset_brownout_pkg::apb_req_s apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic core_reset_b,
   output logic monitor_enable,
   output logic brownout_level_select,
   output logic bandgap_force_on,
   output logic brownout_reset
);
   typedef struct packed {
      logic [1:0] sync;
      reset_brownout_pkg::seq_e seq;
      logic [31:0] delay_count;
      logic [31:0] filter_count;
      logic soft_brownout_enable;
      logic brownout_fast_start;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic core_reset_b;
      logic monitor_enable;
      logic level;
      logic bandgap;
      logic brownout_reset;
   } state_s;

   state_s state;
   state_s next_state;
   logic rst_int_b;
   logic [1:0] rst_pipe;
   logic power_fail;
   logic other_src;
   logic start_wait;
   logic mon_on;
   logic bo_raw;
   logic access;
   logic complete;

   // Async assert, sync release of the reset used everywhere else
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_int_b = rst_pipe[1];

   always_comb begin
      mon_on = 1'b0;
      start_wait = 1'b0;
      unique case (fuse.brownout_mode_select)
         reset_brownout_pkg::MODE_ALWAYS_ON: begin
            mon_on = 1'b1;
            start_wait = 1'b1;
         end
         reset_brownout_pkg::MODE_OFF_IN_SLEEP: begin
            mon_on = !sleep_mode;
            start_wait = 1'b1;
         end
         reset_brownout_pkg::MODE_SOFTWARE: begin
            mon_on = state.soft_brownout_enable;
            start_wait = 1'b0;
         end
         reset_brownout_pkg::MODE_ALWAYS_OFF: begin
            mon_on = 1'b0;
            start_wait = 1'b0;
         end
      endcase
   end

   // Protection counts only once the circuit reports ready
   assign bo_raw = mon_on && monitor.monitor_ready && monitor.below_threshold;
   assign access = apb_req.psel && apb_req.penable && !state.pready;
   assign complete = apb_req.psel && apb_req.penable && state.pready;
   assign other_src = source.external_reset_pin || source.watchdog_reset ||
      source.reset_instruction || source.stack_overflow ||
      source.stack_underflow || source.programming_exit;

   always_comb begin
      next_state = state;
      next_state.sync = {state.sync[0], 1'b1};
      // Filter: short dips reset the count and never trip
      if (bo_raw) begin
         if (state.filter_count < 32'(FILTER_CYCLES)) begin
            next_state.filter_count = state.filter_count + 32'h1;
         end
      end else begin
         next_state.filter_count = 32'h0;
      end
      next_state.brownout_reset = (bo_raw &&
         state.filter_count >= 32'(FILTER_CYCLES)) ||
         (fuse.low_power_undervolt_enable &&
         monitor.low_power_undervolt_detect);
      power_fail = monitor.power_on_hold || state.brownout_reset;
      unique case (state.seq)
         reset_brownout_pkg::ST_HOLD: begin
            next_state.delay_count = 32'h0;
            if (!power_fail) begin
               if (!fuse.powerup_delay_enable_n) begin
                  next_state.seq = reset_brownout_pkg::ST_DELAY;
               end else begin
                  next_state.seq = reset_brownout_pkg::ST_RUN;
               end
            end
         end
         reset_brownout_pkg::ST_DELAY: begin
            next_state.delay_count = state.delay_count + 32'h1;
            if (power_fail) begin
               next_state.seq = reset_brownout_pkg::ST_HOLD;
            end else if (state.delay_count >= 32'(POWERUP_CYCLES - 1)) begin
               next_state.seq = reset_brownout_pkg::ST_RUN;
            end
         end
         reset_brownout_pkg::ST_RUN: begin
            if (power_fail) begin
               next_state.seq = reset_brownout_pkg::ST_HOLD;
            end
         end
      endcase
      // Soft enable returns to one on power or brown-out events only
      if (power_fail) begin
         next_state.soft_brownout_enable = reset_brownout_pkg::SOFT_ENABLE_RESET;
         next_state.brownout_fast_start = reset_brownout_pkg::FAST_START_RESET;
      end
      // Write lands on the edge that completes the transfer, not earlier
      if (complete && apb_req.pwrite && !power_fail &&
         apb_req.paddr[11:0] ==
         reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS) begin
         next_state.soft_brownout_enable =
            apb_req.pwdata[reset_brownout_pkg::SOFT_ENABLE_BIT];
         next_state.brownout_fast_start =
            apb_req.pwdata[reset_brownout_pkg::FAST_START_BIT];
      end
      next_state.pready = access;
      next_state.pslverr = 1'b0;
      next_state.prdata = 32'h0;
      if (access) begin
         unique case (apb_req.paddr[11:0])
            reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS: begin
               next_state.prdata[reset_brownout_pkg::SOFT_ENABLE_BIT] =
                  state.soft_brownout_enable;
               next_state.prdata[reset_brownout_pkg::FAST_START_BIT] =
                  state.brownout_fast_start;
               next_state.prdata[reset_brownout_pkg::READY_BIT] =
                  state.monitor_enable && monitor.monitor_ready;
            end
            reset_brownout_pkg::ADDR_RESET_STATUS: begin
               next_state.prdata[2:0] = state.seq;
            end
            default: begin
               next_state.pslverr = 1'b1;
            end
         endcase
      end
      // Pin and other sources gate only execution, timer runs on
      // Level gates start-up only; once running, only the filter may reset
      next_state.core_reset_b = (state.seq == reset_brownout_pkg::ST_RUN) &&
         !power_fail && !other_src && !(start_wait && mon_on &&
         (!monitor.monitor_ready ||
         (monitor.below_threshold && !state.core_reset_b))) &&
         state.sync[1];
      next_state.monitor_enable = mon_on;
      next_state.level = fuse.brownout_level_select;
      next_state.bandgap = ((fuse.brownout_mode_select ==
         reset_brownout_pkg::MODE_OFF_IN_SLEEP) ||
         (fuse.brownout_mode_select == reset_brownout_pkg::MODE_SOFTWARE)) &&
         state.brownout_fast_start;
   end

   always_ff @(posedge clk_sys or negedge rst_int_b) begin
      if (!rst_int_b) begin
         state <= '0;
         state.seq <= reset_brownout_pkg::ST_HOLD;
         state.soft_brownout_enable <= reset_brownout_pkg::SOFT_ENABLE_RESET;
         state.brownout_fast_start <= reset_brownout_pkg::FAST_START_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign core_reset_b = state.core_reset_b;
   assign monitor_enable = state.monitor_enable;
   assign brownout_level_select = state.level;
   assign bandgap_force_on = state.bandgap;
   assign brownout_reset = state.brownout_reset;

   property p_delay_holds;
      @(posedge clk_sys) disable iff (!rst_int_b)
      state.seq == reset_brownout_pkg::ST_DELAY |=> !core_reset_b;
   endproperty
   a_delay_holds: assert property (p_delay_holds)
      else $error("core left reset during delay");

   property p_por_holds;
      @(posedge clk_sys) disable iff (!rst_int_b)
      monitor.power_on_hold |=> !core_reset_b;
   endproperty
   a_por_holds: assert property (p_por_holds)
      else $error("core out of reset while power low");

   property p_source_holds;
      @(posedge clk_sys) disable iff (!rst_int_b)
      other_src |=> !core_reset_b;
   endproperty
   a_source_holds: assert property (p_source_holds)
      else $error("reset source ignored");

   property p_lp_or;
      @(posedge clk_sys) disable iff (!rst_int_b)
      fuse.low_power_undervolt_enable && monitor.low_power_undervolt_detect
      |=> brownout_reset;
   endproperty
   a_lp_or: assert property (p_lp_or)
      else $error("low power detect not merged");

   property p_short_dip;
      @(posedge clk_sys) disable iff (!rst_int_b)
      $rose(bo_raw) && !(fuse.low_power_undervolt_enable &&
      monitor.low_power_undervolt_detect) |=> !brownout_reset;
   endproperty
   a_short_dip: assert property (p_short_dip)
      else $error("brown-out without filter");

   property p_mode_off;
      @(posedge clk_sys) disable iff (!rst_int_b)
      fuse.brownout_mode_select == reset_brownout_pkg::MODE_ALWAYS_OFF
      |=> !monitor_enable;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("monitor on in off mode");

   property p_bandgap;
      @(posedge clk_sys) disable iff (!rst_int_b)
      fuse.brownout_mode_select[1] == fuse.brownout_mode_select[0]
      |=> !bandgap_force_on;
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("fast start acted in forced mode");

   property p_level;
      @(posedge clk_sys) disable iff (!rst_int_b)
      ##1 brownout_level_select == $past(fuse.brownout_level_select);
   endproperty
   a_level: assert property (p_level)
      else $error("level select not passed");

   property p_start_delay;
      @(posedge clk_sys) disable iff (!rst_int_b)
      state.seq == reset_brownout_pkg::ST_HOLD && !power_fail &&
      !fuse.powerup_delay_enable_n |=>
      state.seq == reset_brownout_pkg::ST_DELAY;
   endproperty
   a_start_delay: assert property (p_start_delay)
      else $error("delay timer did not start");

   sequence s_apb_access;
      apb_req.psel && apb_req.penable && !pready;
   endsequence

   sequence s_apb_answer;
      pready ##1 !pready;
   endsequence

   sequence s_control_read;
      s_apb_access ##0 !apb_req.pwrite &&
      apb_req.paddr[11:0] == reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS;
   endsequence

   sequence s_wake_unready;
      fuse.brownout_mode_select == reset_brownout_pkg::MODE_OFF_IN_SLEEP &&
      $fell(sleep_mode) && !monitor.monitor_ready;
   endsequence

   property p_apb_answer;
      @(posedge clk_sys) disable iff (!rst_int_b)
      s_apb_access |=> s_apb_answer;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("bus answer not after one wait state");

   property p_ready_read;
      @(posedge clk_sys) disable iff (!rst_int_b)
      s_control_read |=> prdata[reset_brownout_pkg::READY_BIT] ==
         $past(monitor_enable && monitor.monitor_ready);
   endproperty
   a_ready_read: assert property (p_ready_read)
      else $error("ready flag does not follow circuit");

   property p_write_lands;
      @(posedge clk_sys) disable iff (!rst_int_b)
      apb_req.psel && apb_req.penable && pready && apb_req.pwrite &&
      !power_fail && apb_req.paddr[11:0] ==
      reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS |=>
      state.soft_brownout_enable ==
      $past(apb_req.pwdata[reset_brownout_pkg::SOFT_ENABLE_BIT]);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("soft enable write lost");

   property p_fail_defaults;
      @(posedge clk_sys) disable iff (!rst_int_b)
      power_fail |=> state.soft_brownout_enable ==
      reset_brownout_pkg::SOFT_ENABLE_RESET &&
      state.brownout_fast_start == reset_brownout_pkg::FAST_START_RESET;
   endproperty
   a_fail_defaults: assert property (p_fail_defaults)
      else $error("control bits not restored on power fail");

   property p_delay_ends;
      @(posedge clk_sys) disable iff (!rst_int_b)
      state.seq == reset_brownout_pkg::ST_DELAY && !power_fail &&
      state.delay_count >= 32'(POWERUP_CYCLES - 1) |=>
      state.seq == reset_brownout_pkg::ST_RUN;
   endproperty
   a_delay_ends: assert property (p_delay_ends)
      else $error("delay timer overran");

   property p_filter_trip;
      @(posedge clk_sys) disable iff (!rst_int_b)
      bo_raw && state.filter_count >= 32'(FILTER_CYCLES) |=> brownout_reset;
   endproperty
   a_filter_trip: assert property (p_filter_trip)
      else $error("long dip did not trip");

   property p_startup_level;
      @(posedge clk_sys) disable iff (!rst_int_b)
      start_wait && mon_on && !core_reset_b && monitor.below_threshold
      |=> !core_reset_b;
   endproperty
   a_startup_level: assert property (p_startup_level)
      else $error("start-up ignored low supply");

   property p_wake_wait;
      @(posedge clk_sys) disable iff (!rst_int_b)
      s_wake_unready |=> !core_reset_b;
   endproperty
   a_wake_wait: assert property (p_wake_wait)
      else $error("wake did not wait for ready");

   property p_wake_quick;
      @(posedge clk_sys) disable iff (!rst_int_b)
      fuse.brownout_mode_select == reset_brownout_pkg::MODE_ALWAYS_ON &&
      $fell(sleep_mode) && core_reset_b && monitor.monitor_ready &&
      !power_fail && !other_src |=> core_reset_b;
   endproperty
   a_wake_quick: assert property (p_wake_quick)
      else $error("wake delayed in always-on mode");
endmodule : reset_brownout_sequencer

// *** verification/analog_monitor_model.sv ***
`timescale 1ns/100ps
// Supply comparators; ready comes 8 cycles after the monitor is switched on
module analog_monitor_model (
   input wire logic clk_sys,
   input wire logic monitor_enable,
   input wire logic hold,
   input wire logic dip,
   input wire logic lp,
   output reset_brownout_pkg::monitor_s monitor
);
   logic [3:0] warm = 4'h0;
   always @(posedge clk_sys) begin
      warm <= monitor_enable ? warm + {3'h0, !warm[3]} : 4'h0;
   end
   // Slow ready so that start-up waits can be seen at the core reset
   assign monitor = {hold, dip, warm[3], lp};
endmodule : analog_monitor_model

// *** verification/reset_brownout_sequencer_tb_top.sv ***
`timescale 1ns/100ps
module reset_brownout_sequencer_tb_top;
   logic clk_sys = 0, rst_b = 0, sleep_mode = 0;
   logic hold = 1, dip = 0, lp = 0, e, level, bandgap, bo_reset;
   reset_brownout_pkg::fuse_s fuse = 5'h01;
   reset_brownout_pkg::source_s source = 6'h00;
   reset_brownout_pkg::apb_req_s apb_req = '0;
   reset_brownout_pkg::monitor_s monitor;
   logic [31:0] prdata, rd;
   logic pready, pslverr, core_reset_b, monitor_enable;
   int error_cnt = 0, checked = 0, n;
   // Row: mode, sleep, expected monitor on, expected bandgap forced
   logic [4:0] rows [7] = '{5'h1A, 5'h1E, 5'h13, 5'h15, 5'h0B, 5'h0F, 5'h00};
   always #5 clk_sys = ~clk_sys;
   reset_brownout_sequencer #(.POWERUP_CYCLES(20), .FILTER_CYCLES(4)) uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .fuse(fuse), .monitor(monitor),
      .source(source), .sleep_mode(sleep_mode), .apb_req(apb_req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_reset_b(core_reset_b), .monitor_enable(monitor_enable),
      .brownout_level_select(level), .bandgap_force_on(bandgap),
      .brownout_reset(bo_reset));
   analog_monitor_model model (.clk_sys(clk_sys),
      .monitor_enable(monitor_enable), .hold(hold), .dip(dip), .lp(lp),
      .monitor(monitor));
   task stop_test;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task chk_word(input logic [31:0] got, exp, input string msg);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk_word
   task chk_bit(input logic got, exp, input string msg);
      chk_word({31'h0, got}, {31'h0, exp}, msg);
   endtask : chk_bit
   task tick(input int k);
      repeat (k) @(posedge clk_sys);
   endtask : tick
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      apb_req <= {20'h0, a, 1'b1, 1'b0, wr, d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      e = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      chk_bit(k < 20, 1'b1, "bus answer");
      if (k == 20) stop_test();
   endtask : apb
   task wait_core(input int lo, hi, input string msg);
      n = 0;
      while (core_reset_b !== 1'b1 && n < hi) begin
         tick(1);
         n++;
      end
      chk_bit(core_reset_b === 1'b1 && n >= lo, 1'b1, msg);
      if (core_reset_b !== 1'b1) stop_test();
   endtask : wait_core
   task power_cycle;
      hold <= 1'b1;
      tick(3);
      hold <= 1'b0;
   endtask : power_cycle
   initial begin
      tick(12);
      rst_b <= 1'b1;
      tick(3);
      chk_bit(core_reset_b, 1'b0, "held while supply low");
      apb(1'b1, reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS, 32'h40);
      apb(1'b0, reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS, 32'h0);
      chk_word(rd, 32'h80, "control defaults");
      hold <= 1'b0;
      wait_core(20, 26, "delay timer");
      $display("power-up done");
      fuse.powerup_delay_enable_n <= 1'b1;
      power_cycle();
      wait_core(0, 5, "timer off");
      fuse.powerup_delay_enable_n <= 1'b0;
      source.external_reset_pin <= 1'b1;
      power_cycle();
      tick(40);
      chk_bit(core_reset_b, 1'b0, "pin holds");
      source.external_reset_pin <= 1'b0;
      wait_core(0, 4, "pin release");
      apb(1'b1, reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS, 32'h0);
      for (int i = 0; i < 6; i++) begin
         source <= 6'h01 << i;
         tick(3);
         chk_bit(core_reset_b, 1'b0, "source reset");
         source <= 6'h00;
         wait_core(0, 5, "source release");
      end
      apb(1'b0, reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS, 32'h0);
      chk_word(rd, 32'h00, "soft enable kept");
      $display("sources done");
      apb(1'b1, reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS, 32'hC0);
      foreach (rows[i]) begin
         fuse.brownout_mode_select <= rows[i][4:3];
         sleep_mode <= rows[i][2];
         tick(14);
         chk_bit(monitor_enable, rows[i][1], "mode");
         chk_bit(bandgap, rows[i][0], "fast start");
         chk_bit(core_reset_b, 1'b1, "no hold");
         apb(1'b0, reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS, 32'h0);
         chk_word(rd, {24'h0, 7'h60, rows[i][1]}, "ready flag");
      end
      $display("modes done");
      fuse.brownout_mode_select <= 2'h1;
      apb(1'b1, reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS, 32'h0);
      tick(4);
      chk_bit(monitor_enable, 1'b0, "soft off");
      fuse.brownout_mode_select <= 2'h3;
      tick(4);
      chk_bit(core_reset_b, 1'b0, "waits for ready");
      wait_core(0, 12, "ready reached");
      sleep_mode <= 1'b1;
      tick(3);
      chk_bit(monitor_enable, 1'b1, "on in sleep");
      sleep_mode <= 1'b0;
      tick(2);
      chk_bit(core_reset_b, 1'b1, "wake not delayed");
      dip <= 1'b1;
      tick(4);
      dip <= 1'b0;
      tick(4);
      chk_bit(bo_reset, 1'b0, "short dip");
      chk_bit(core_reset_b, 1'b1, "short dip ignored");
      dip <= 1'b1;
      tick(10);
      chk_bit(bo_reset, 1'b1, "long dip");
      chk_bit(core_reset_b, 1'b0, "brown-out hold");
      dip <= 1'b0;
      wait_core(20, 40, "brown-out restart");
      apb(1'b0, reset_brownout_pkg::ADDR_BROWNOUT_CONTROL_STATUS, 32'h0);
      chk_word(rd, 32'h81, "soft enable restored");
      lp <= 1'b1;
      tick(3);
      chk_bit(bo_reset, 1'b1, "low-power detect");
      lp <= 1'b0;
      wait_core(20, 40, "low-power restart");
      fuse.brownout_level_select <= 1'b1;
      tick(3);
      chk_bit(level, 1'b1, "level select");
      apb(1'b0, 12'h008, 32'h0);
      chk_bit(e, 1'b1, "unmapped error");
      chk_word(rd, 32'h0, "unmapped data");
      apb(1'b0, reset_brownout_pkg::ADDR_RESET_STATUS, 32'h0);
      chk_word(rd, 32'h4, "sequencer running");
      fuse.brownout_mode_select <= 2'h2;
      sleep_mode <= 1'b1;
      tick(4);
      chk_bit(monitor_enable, 1'b0, "off in sleep");
      sleep_mode <= 1'b0;
      tick(3);
      chk_bit(core_reset_b, 1'b0, "wake waits");
      wait_core(0, 12, "wake ready");
      $display("brown-out done");
      stop_test();
   end
endmodule : reset_brownout_sequencer_tb_top
